// *** slpin_board.sv ***
/*
  Board model: strap resistors and the system reset source.
  Assumes the bench sets the commands at the falling clock edge.
*/
`timescale 1ns/10ps
module slpin_board (
  // Commands from the bench
  input wire logic reset_req_in,
  input wire logic float_in,
  input wire slpin_pkg::slpin_straps_t level_in,
  // Board pins
  output logic system_reset_n_out,
  output slpin_pkg::slpin_straps_t straps_out
);
  import slpin_pkg::*;
  // ==========================================================================
  // Pins
  // ==========================================================================
  // Reset pin is pulled high unless the board pulls it low
  assign system_reset_n_out = !reset_req_in;
  // Floating straps settle to the internal pulls
  assign straps_out = float_in ? {REG_OFF_DEFAULT, IRQSEL_DEFAULT} : level_in;
endmodule : slpin_board

// *** slpin_pkg.sv ***
/*
  Shared types and constants for the strap latch, LED and pin select block.
  Assumes one 25 MHz clock domain; no register bus.
*/
package slpin_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 40;
  // Activity blink half period, in microseconds
  localparam int BLINK_HALF_US = 80000;
  localparam int BLINK_HALF_CYC = (BLINK_HALF_US * 1000) / CLK_PERIOD_NS;
  localparam int BLINK_CNT_W = 22;

  // ==========================================================================
  // Strap defaults and levels
  // ==========================================================================
  localparam logic LVL_ON = 1'b1;
  localparam logic LVL_OFF = 1'b0;
  // Regulator-off strap has a pull-down: default is regulator enabled
  localparam logic REG_OFF_DEFAULT = 1'b0;
  // Interrupt-select strap has a pull-up: default is interrupt function
  localparam logic IRQSEL_DEFAULT = 1'b1;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic regulator_off_strap;
    logic irq_function_select_strap;
  } slpin_straps_t;

  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic isolated;
    logic activity;
    logic carrier;
    logic mii_mode;
  } slpin_core_t;

  typedef enum logic {
    SLPIN_PIN_IRQ,
    SLPIN_PIN_TXER
  } slpin_pinsel_t;

endpackage : slpin_pkg

// *** slpin_sync2.sv ***
/*
  Two flip-flop synchroniser for a bus of asynchronous levels.
  Assumes the inputs come from pins outside the clock domain.
*/
`timescale 1ns/10ps
module slpin_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("slpin_sync2: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_ff <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule : slpin_sync2

// *** slpin_top.sv ***
/*
  Strap latch, LED drive and shared pin select for a 10/100 transceiver.
  Assumes core status inputs are on clk_in; strap pins and the system reset
  pin are asynchronous and are synchronised here.
*/
`timescale 1ns/10ps

// How it works
// - In MII mode, carrier sense output follows carrier detection on the line.
// - Straps are captured at power-on and each system reset, held until next.
// - Activity LED is on with valid link and blinks while activity is seen.
// - Speed LED is on at 100 Mbps, off at 10 Mbps or when isolated.
// - Latched regulator-off strap high disables core regulator; low keeps it on.
// - Interrupt-select strap high selects interrupt pin, low selects TXER/TXD4.
module slpin_top #(
  parameter int BLINK_HALF = slpin_pkg::BLINK_HALF_CYC
) (
  // Clock and power-on reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Board system reset, active low
  input wire logic system_reset_n_in,
  // Strap pins
  input wire slpin_pkg::slpin_straps_t straps_in,
  // Core status, same clock
  input wire slpin_pkg::slpin_core_t core_in,
  // Core interrupt request
  input wire logic core_irq_in,
  // Latched configuration
  output slpin_pkg::slpin_straps_t straps_latched_out,
  output logic regulator_enable_out,
  output slpin_pkg::slpin_pinsel_t pin_function_out,
  output logic straps_valid_out,
  // Pins
  output logic link_activity_led_out,
  output logic link_speed_led_out,
  output logic crs_out,
  output logic irq_out_n_out,
  output logic irq_out_n_oe_out
);
  import slpin_pkg::*;

  if (BLINK_HALF < 2 || BLINK_HALF >= (1 << BLINK_CNT_W))
  begin : g_bad_blink
    $error("slpin_top: BLINK_HALF out of range");
  end

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int SYNC_W = 1 + $bits(slpin_straps_t);
  localparam slpin_straps_t STRAPS_DEFAULT = '{regulator_off_strap: REG_OFF_DEFAULT,
                                              irq_function_select_strap: IRQSEL_DEFAULT};

  logic sys_rst_n_sync;
  slpin_straps_t straps_sync;
  logic [SYNC_W-1:0] sync_bus;

  // Reset pin and straps share one synchroniser so they age together
  slpin_sync2 #(.WIDTH(SYNC_W), .RESET_VAL({LVL_OFF, STRAPS_DEFAULT})) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in({system_reset_n_in, straps_in}),
    .sync_out(sync_bus)
  );

  assign sys_rst_n_sync = sync_bus[SYNC_W-1];
  assign straps_sync = sync_bus[SYNC_W-2:0];

  // ==========================================================================
  // Strap latch
  // ==========================================================================
  // Any reset, power-on or system, holds the block and rearms the latch
  logic in_reset_ff;
  logic nxt_in_reset;
  slpin_straps_t straps_ff;
  logic capture;

  assign nxt_in_reset = !sys_rst_n_sync;
  assign capture = in_reset_ff && sys_rst_n_sync;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      in_reset_ff <= LVL_ON;
    end
    else
    begin
      in_reset_ff <= nxt_in_reset;
    end
  end

  // Captured at the release edge only; the pins are free afterwards
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      straps_ff <= STRAPS_DEFAULT;
    end
    else if (capture)
    begin
      straps_ff <= straps_sync;
    end
  end

  assign straps_latched_out = straps_ff;
  assign straps_valid_out = !in_reset_ff;
  assign regulator_enable_out = !straps_ff.regulator_off_strap;
  assign pin_function_out = straps_ff.irq_function_select_strap ? SLPIN_PIN_IRQ : SLPIN_PIN_TXER;

  // ==========================================================================
  // Shared interrupt pin, open drain
  // ==========================================================================
  logic irq_drive_ff;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_drive_ff <= LVL_OFF;
    end
    else
    begin
      irq_drive_ff <= (pin_function_out == SLPIN_PIN_IRQ) && !in_reset_ff && core_irq_in;
    end
  end

  assign irq_out_n_out = LVL_OFF;
  assign irq_out_n_oe_out = irq_drive_ff;

  // ==========================================================================
  // LEDs and carrier sense
  // ==========================================================================
  logic [BLINK_CNT_W-1:0] blink_cnt_ff;
  logic blink_phase_ff;
  logic led_act_ff;
  logic led_spd_ff;
  logic crs_ff;
  logic blink_wrap;

  assign blink_wrap = (blink_cnt_ff == BLINK_CNT_W'(BLINK_HALF - 1));

  // Blink timer runs only during activity so each burst starts with a lit phase
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      blink_cnt_ff <= '0;
      blink_phase_ff <= LVL_OFF;
    end
    else if (!core_in.activity || in_reset_ff)
    begin
      blink_cnt_ff <= '0;
      blink_phase_ff <= LVL_OFF;
    end
    else if (blink_wrap)
    begin
      blink_cnt_ff <= '0;
      blink_phase_ff <= !blink_phase_ff;
    end
    else
    begin
      blink_cnt_ff <= blink_cnt_ff + BLINK_CNT_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      led_act_ff <= LVL_OFF;
      led_spd_ff <= LVL_OFF;
      crs_ff <= LVL_OFF;
    end
    else
    begin
      led_act_ff <= !in_reset_ff && core_in.link_up && !blink_phase_ff;
      led_spd_ff <= !in_reset_ff && core_in.speed_100 && !core_in.isolated;
      crs_ff <= !in_reset_ff && core_in.mii_mode && core_in.carrier;
    end
  end

  assign link_activity_led_out = led_act_ff;
  assign link_speed_led_out = led_spd_ff;
  assign crs_out = crs_ff;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_release;
    in_reset_ff && sys_rst_n_sync;
  endsequence

  chk_strap_capture: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_release |=> (straps_ff == $past(straps_sync)))
    else $error("straps not captured at release");

  chk_strap_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !in_reset_ff && !$past(in_reset_ff) |-> $stable(straps_ff))
    else $error("straps changed outside reset release");

  chk_regulator_sel: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_release |=> (regulator_enable_out == !$past(straps_sync.regulator_off_strap)))
    else $error("regulator enable wrong");

  chk_pin_function: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !straps_ff.irq_function_select_strap |=> !irq_out_n_oe_out)
    else $error("interrupt driven in TXER mode");

  chk_crs_follow: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !in_reset_ff && core_in.mii_mode && core_in.carrier |=> crs_out)
    else $error("carrier sense missing");

  chk_speed_led: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    core_in.isolated || !core_in.speed_100 |=> !link_speed_led_out)
    else $error("speed LED on at 10M or isolated");

  chk_link_led: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!in_reset_ff && core_in.link_up && !core_in.activity)[*2] |=> link_activity_led_out)
    else $error("link LED dark on idle link");

  chk_reset_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !sys_rst_n_sync |=> in_reset_ff ##1 !crs_out)
    else $error("system reset not honoured");

endmodule : slpin_top

// *** tb.sv ***
/*
  Self-checking bench for the strap latch, LED and pin select block.
  Assumes a shortened blink half period and the board model beside it.
*/
`timescale 1ns/10ps
module tb;
  import slpin_pkg::*;
  localparam int BH = 4;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic reset_req = 1'b0;
  logic float_s = 1'b1;
  logic core_irq = 1'b0;
  slpin_straps_t lvl = '0;
  slpin_core_t core = '0;
  slpin_straps_t straps_pin;
  slpin_straps_t latched;
  slpin_pinsel_t pfn;
  logic sys_n, reg_en, valid, led_act, led_spd, crs, irq_n, irq_oe;
  int n_fail = 0;
  int comparisons = 0;
  always #20 clk_in = ~clk_in;
  slpin_board board (.reset_req_in(reset_req), .float_in(float_s), .level_in(lvl),
    .system_reset_n_out(sys_n), .straps_out(straps_pin));
  slpin_top #(.BLINK_HALF(BH)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .system_reset_n_in(sys_n),
    .straps_in(straps_pin), .core_in(core), .core_irq_in(core_irq), .straps_latched_out(latched),
    .regulator_enable_out(reg_en), .pin_function_out(pfn), .straps_valid_out(valid),
    .link_activity_led_out(led_act), .link_speed_led_out(led_spd), .crs_out(crs),
    .irq_out_n_out(irq_n), .irq_out_n_oe_out(irq_oe));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_cfg(input slpin_straps_t got, input slpin_straps_t exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_cfg
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_in);
  endtask : cyc
  // Bounded wait; the latch needs a few edges after release
  task automatic wait_valid();
    int i;
    i = 0;
    while (valid !== 1'b1 && i < 20)
    begin
      cyc(1);
      i++;
    end
    chk_bit(valid, 1'b1);
  endtask : wait_valid
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Every strap combination plus floating pins, each through a system reset
  task automatic t_straps();
    slpin_straps_t exp;
    for (int k = 0; k < 5; k++)
    begin
      float_s = (k == 4);
      lvl = 2'(k);
      exp = (k == 4) ? {REG_OFF_DEFAULT, IRQSEL_DEFAULT} : 2'(k);
      core_irq = 1'b1;
      core.speed_100 = 1'b1;
      reset_req = 1'b1;
      cyc(5);
      chk_bit(valid, 1'b0);
      chk_bit(irq_oe, 1'b0);
      chk_bit(led_spd, 1'b0);
      reset_req = 1'b0;
      wait_valid();
      // Straps flipped after capture must not reach the latch
      lvl = ~exp;
      float_s = 1'b0;
      cyc(4);
      chk_cfg(latched, exp);
      chk_bit(reg_en, !exp.regulator_off_strap);
      chk_bit(pfn == SLPIN_PIN_TXER, !exp.irq_function_select_strap);
      chk_bit(irq_oe, exp.irq_function_select_strap);
      chk_bit(irq_n, 1'b0);
      chk_bit(led_spd, 1'b1);
      core_irq = 1'b0;
      cyc(2);
      chk_bit(irq_oe, 1'b0);
    end
  endtask : t_straps
  // Power-on reset in mid-run rearms the latch and takes non-default straps
  task automatic t_por();
    slpin_straps_t exp;
    exp = '{regulator_off_strap: 1'b1, irq_function_select_strap: 1'b0};
    float_s = 1'b0;
    lvl = exp;
    rst_b_in = 1'b0;
    cyc(2);
    chk_bit(valid, 1'b0);
    chk_cfg(latched, {REG_OFF_DEFAULT, IRQSEL_DEFAULT});
    chk_bit(reg_en, 1'b1);
    rst_b_in = 1'b1;
    wait_valid();
    chk_cfg(latched, exp);
    chk_bit(reg_en, 1'b0);
    chk_bit(pfn == SLPIN_PIN_TXER, 1'b1);
  endtask : t_por
  task automatic t_status();
    int on;
    int off;
    core.mii_mode = 1'b1;
    core.carrier = 1'b1;
    cyc(2);
    chk_bit(crs, 1'b1);
    core.carrier = 1'b0;
    cyc(2);
    chk_bit(crs, 1'b0);
    // Carrier outside MII mode must not reach the carrier sense output
    core.mii_mode = 1'b0;
    core.carrier = 1'b1;
    cyc(2);
    chk_bit(crs, 1'b0);
    core.carrier = 1'b0;
    core.speed_100 = 1'b1;
    cyc(2);
    chk_bit(led_spd, 1'b1);
    core.isolated = 1'b1;
    cyc(2);
    chk_bit(led_spd, 1'b0);
    core.isolated = 1'b0;
    core.speed_100 = 1'b0;
    cyc(2);
    chk_bit(led_spd, 1'b0);
    core.link_up = 1'b1;
    cyc(2);
    chk_bit(led_act, 1'b1);
    core.activity = 1'b1;
    on = 0;
    off = 0;
    repeat (4 * BH)
    begin
      cyc(1);
      if (led_act === 1'b1)
        on++;
      else
        off++;
    end
    chk_bit(on == 2 * BH && off == 2 * BH, 1'b1);
    core.activity = 1'b0;
    core.link_up = 1'b0;
    cyc(2);
    chk_bit(led_act, 1'b0);
  endtask : t_status
  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial
  begin
    cyc(6);
    rst_b_in = 1'b1;
    wait_valid();
    chk_cfg(latched, {REG_OFF_DEFAULT, IRQSEL_DEFAULT});
    t_straps();
    t_por();
    t_status();
    complete_run();
  end
  // Whole run needs well under 1000 cycles
  initial
  begin
    #100000;
    n_fail++;
    complete_run();
  end
endmodule : tb
